// File: test/test_swi_core.sv
/*
 * Self-checking bench for the sleep/wake race controller: power-down
 * as no-op, normal sleep and wake, late wake, watchdog wake, event irq.
 * Assumes the single slave's hreadyout is fed back as hready.
 */
`timescale 1ns/1ps
module test_swi_core;
	localparam int NS = swi_pkg::N_SRC;
	localparam int WB = 16;
	localparam int LIM = 200;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic hready;
	logic hreadyout, hresp, osc_run, sleeping, vector_branch, wdt_reset;
	logic sleep_entered_n, watchdog_expired_n, irq;
	logic [31:0] hrdata;
	logic [NS-1:0] irq_src_set = '0;
	logic [31:0] exp_q[$];
	logic rd_pend = 1'b0;
	logic sleep_seen = 1'b0;
	logic [31:0] vcnt = 32'h0;
	logic [31:0] wcnt = 32'h0;
	logic [31:0] fails = 32'h0;
	logic [31:0] n_compared = 32'h0;
	int b, c, seed;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	always #20 hclk = ~hclk;

	swi_core #(.N_SRC(NS), .WDT_BASE_CYC(WB)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq_src_set(irq_src_set),
		.osc_run(osc_run), .sleeping(sleeping),
		.vector_branch(vector_branch), .wdt_reset(wdt_reset),
		.sleep_entered_n(sleep_entered_n),
		.watchdog_expired_n(watchdog_expired_n), .irq(irq));

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 32'h0 && n_compared != 32'h0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic cmp_pin(input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	// Read monitor: a taken read's data stands in the following cycle
	always @(posedge hclk) begin
		rd_pend <= hsel && hready && htrans[1] && !hwrite;
	end
	always @(negedge hclk) begin
		if (rd_pend) begin
			if (exp_q.size() == 0) begin
				cmp_rd(32'hffffffff, hrdata);
			end else begin
				cmp_rd(exp_q.pop_front(), hrdata);
			end
		end
	end

	// Pulse counters and sleep witness
	always @(posedge hclk) begin
		if (vector_branch === 1'b1) vcnt <= vcnt + 32'h1;
		if (wdt_reset === 1'b1) wcnt <= wcnt + 32'h1;
		if (sleeping === 1'b1) sleep_seen <= 1'b1;
	end

	task automatic bounded(input int n);
		if (n >= LIM) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, 32'h0, n);
			end_of_test();
		end
	endtask

	// One AHB single transfer; a read notes its expected data first
	task automatic ahb(input logic [7:0] a, input logic w,
			input logic [31:0] d);
		int n;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= swi_pkg::HSIZE_WORD;
		if (!w) exp_q.push_back(d);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < LIM);
		bounded(n);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < LIM);
		bounded(n);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		ahb(a, 1'b0, e);
	endtask

	task automatic pulse(input logic [NS-1:0] m);
		@(posedge hclk);
		irq_src_set <= m;
		@(posedge hclk);
		irq_src_set <= '0;
	endtask

	// Wait for sleeping (k=0) or irq (k=1) to reach v
	task automatic waitv(input int k, input logic v);
		int n;
		logic g;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			g = (k == 0) ? sleeping : irq;
		end while (g !== v && n < LIM);
		bounded(n);
	endtask

	// Clear events and flags, then restore both status flags
	task automatic tidy();
		wr(swi_pkg::ADDR_EVT, 32'h7);
		wr(swi_pkg::ADDR_SRC_FLAG, 32'hff);
		wr(swi_pkg::ADDR_CMD, 32'h2);
		rd(swi_pkg::ADDR_STATUS, 32'h18);
	endtask

	initial begin
		seed = $urandom(32'h25b6);
		b = $urandom_range(NS - 1, 0);
		c = (b + 1) % NS;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rd(swi_pkg::ADDR_CTRL, 32'h2);
		// Watchdog off early: the short test period would expire
		// within a few transfers and disturb the flags
		wr(swi_pkg::ADDR_CTRL, 32'h0);
		rd(swi_pkg::ADDR_STATUS, 32'h18);
		rd(8'h1c, 32'h0);
		rd(swi_pkg::ADDR_CMD, 32'h0);
		cmp_pin(1'b0, hresp);
		cmp_pin(1'b1, hreadyout);
		$display("test reset done");

		// Pending enabled source before power-down, global enable clear
		wr(swi_pkg::ADDR_SRC_EN, 32'h1 << b);
		wr(swi_pkg::ADDR_EVT_MASK, 32'h1);
		pulse(NS'(1) << b);
		rd(swi_pkg::ADDR_SRC_FLAG, 32'h1 << b);
		wr(swi_pkg::ADDR_CMD, 32'h1);
		waitv(1, 1'b1);
		cmp_pin(1'b0, sleep_seen);
		rd(swi_pkg::ADDR_STATUS, 32'h18);
		rd(swi_pkg::ADDR_EVT, 32'h1);
		wr(swi_pkg::ADDR_EVT_MASK, 32'h0);
		waitv(1, 1'b0);
		tidy();
		rd(swi_pkg::ADDR_EVT, 32'h0);
		$display("test nop done");

		// Disabled source does not block sleep; enabled one wakes it
		pulse(NS'(1) << c);
		wr(swi_pkg::ADDR_CMD, 32'h1);
		waitv(0, 1'b1);
		cmp_pin(1'b0, osc_run);
		rd(swi_pkg::ADDR_STATUS, 32'h11);
		vcnt <= 32'h0;
		pulse(NS'(1) << b);
		waitv(0, 1'b0);
		cmp_pin(1'b1, osc_run);
		repeat (10) @(posedge hclk);
		cmp_rd(32'h0, vcnt);
		rd(swi_pkg::ADDR_STATUS, 32'h10);
		rd(swi_pkg::ADDR_EVT, 32'h2);
		tidy();
		$display("test sleep wake done");

		// Same wake with global enable set branches once
		wr(swi_pkg::ADDR_CTRL, 32'h1);
		wr(swi_pkg::ADDR_CMD, 32'h1);
		waitv(0, 1'b1);
		vcnt <= 32'h0;
		pulse(NS'(1) << b);
		waitv(0, 1'b0);
		repeat (10) @(posedge hclk);
		cmp_rd(32'h1, vcnt);
		tidy();
		wr(swi_pkg::ADDR_CTRL, 32'h0);
		$display("test vector done");

		// Source arrives while power-down executes: flags set, oscillator stays on
		sleep_seen <= 1'b0;
		wr(swi_pkg::ADDR_CMD, 32'h1);
		repeat (4) @(posedge hclk);
		pulse(NS'(1) << b);
		repeat (15) @(posedge hclk);
		cmp_pin(1'b1, osc_run);
		rd(swi_pkg::ADDR_STATUS, 32'h10);
		cmp_pin(1'b0, sleep_entered_n);
		cmp_pin(1'b1, watchdog_expired_n);
		rd(swi_pkg::ADDR_EVT, 32'h2);
		tidy();
		$display("test late wake done");

		// Watchdog keeps running in sleep and wakes without a reset
		wcnt <= 32'h0;
		wr(swi_pkg::ADDR_CTRL, 32'h6);
		wr(swi_pkg::ADDR_CMD, 32'h2);
		wr(swi_pkg::ADDR_CMD, 32'h1);
		waitv(0, 1'b1);
		waitv(0, 1'b0);
		repeat (6) @(posedge hclk);
		rd(swi_pkg::ADDR_STATUS, 32'h00);
		cmp_pin(1'b0, watchdog_expired_n);
		wr(swi_pkg::ADDR_CTRL, 32'h0);
		cmp_rd(32'h0, wcnt);
		rd(swi_pkg::ADDR_EVT, 32'h6);
		$display("test watchdog wake done");
		end_of_test();
	end

	// Last-resort limit on the whole run
	initial begin
		#4000000;
		fails++;
		end_of_test();
	end
endmodule

// File: verilog/swi_core.sv
/*
 * Sleep/wake controller of a small core: decides whether a power-down
 * command sleeps or degrades to a no-op, handles late wake, keeps the
 * watchdog and the time-out/power-down flags, and exposes it all as an
 * AHB-Lite slave with a maskable event interrupt.
 * Assumes inputs synchronous to hclk and a single AHB-Lite master.
 */
`timescale 1ns/1ps
module swi_core #(
	parameter int N_SRC = swi_pkg::N_SRC,
	parameter int WDT_BASE_CYC = swi_pkg::WDT_BASE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [N_SRC-1:0] irq_src_set,
	output logic osc_run,
	output logic sleeping,
	output logic vector_branch,
	output logic wdt_reset,
	output logic sleep_entered_n,
	output logic watchdog_expired_n,
	output logic irq
);
	localparam int PSW = swi_pkg::PS_W;

	logic acc_c;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic wr_ctrl, wr_en, wr_flag, wr_cmd, wr_evt, wr_mask;
	logic glb_en_r;
	logic wdt_en_r;
	logic [PSW-1:0] ps_r;
	logic [N_SRC-1:0] src_en_r;
	logic [N_SRC-1:0] flag_r;
	logic sleep_req_r;
	logic woke_irq_r;
	logic [swi_pkg::EV_W-1:0] ev_r;
	logic [swi_pkg::EV_W-1:0] ev_mask_r;
	logic [swi_pkg::EV_W-1:0] ev_set_c;
	swi_pkg::swi_state_t st_r, st_nxt;
	logic cyc_en;
	logic wdt_tmo;
	logic wake_c, take_c, nop_c, exec_done_c, wdclr_cmd_c, wdt_clr_c;
	logic [31:0] rd_c;

	// Word hit on the low address byte; upper address bits alias
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	// Address phase: only word-sized NONSEQ/SEQ transfers are taken
	assign acc_c = hsel && hready && htrans[1] &&
		hsize == swi_pkg::HSIZE_WORD;

	// Write address held over into the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= acc_c && hwrite;
			if (acc_c && hwrite) begin
				wr_addr_r <= haddr[7:0];
			end
		end
	end

	assign wr_ctrl = wr_pend_r && hit(wr_addr_r, swi_pkg::ADDR_CTRL);
	assign wr_en = wr_pend_r && hit(wr_addr_r, swi_pkg::ADDR_SRC_EN);
	assign wr_flag = wr_pend_r && hit(wr_addr_r, swi_pkg::ADDR_SRC_FLAG);
	assign wr_cmd = wr_pend_r && hit(wr_addr_r, swi_pkg::ADDR_CMD);
	assign wr_evt = wr_pend_r && hit(wr_addr_r, swi_pkg::ADDR_EVT);
	assign wr_mask = wr_pend_r && hit(wr_addr_r, swi_pkg::ADDR_EVT_MASK);

	// Zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data latched at the end of the address phase
	always_comb begin
		rd_c = 32'h0000_0000;
		unique case ({haddr[7:2], 2'b00})
			swi_pkg::ADDR_CTRL: begin
				rd_c[swi_pkg::CTRL_GLB_EN] = glb_en_r;
				rd_c[swi_pkg::CTRL_WDT_EN] = wdt_en_r;
				rd_c[swi_pkg::CTRL_PS_LSB +: PSW] = ps_r;
			end
			swi_pkg::ADDR_SRC_EN: rd_c[N_SRC-1:0] = src_en_r;
			swi_pkg::ADDR_SRC_FLAG: rd_c[N_SRC-1:0] = flag_r;
			swi_pkg::ADDR_STATUS: begin
				rd_c[swi_pkg::STAT_SLEEPING] = st_r == swi_pkg::ST_SLEEP;
				rd_c[swi_pkg::STAT_RESUMING] = st_r == swi_pkg::ST_RESUME;
				rd_c[swi_pkg::STAT_SLEPT_N] = sleep_entered_n;
				rd_c[swi_pkg::STAT_EXPIRED_N] = watchdog_expired_n;
			end
			swi_pkg::ADDR_EVT: rd_c[swi_pkg::EV_W-1:0] = ev_r;
			swi_pkg::ADDR_EVT_MASK: rd_c[swi_pkg::EV_W-1:0] = ev_mask_r;
			default: rd_c = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (acc_c && !hwrite) begin
			hrdata <= rd_c;
		end
	end

	// Control register: global enable, watchdog enable, postscaler
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			glb_en_r <= swi_pkg::GLB_EN_RST;
			wdt_en_r <= swi_pkg::WDT_EN_RST;
			ps_r <= swi_pkg::PS_RST;
		end else if (wr_ctrl) begin
			glb_en_r <= hwdata[swi_pkg::CTRL_GLB_EN];
			wdt_en_r <= hwdata[swi_pkg::CTRL_WDT_EN];
			ps_r <= hwdata[swi_pkg::CTRL_PS_LSB +: PSW];
		end
	end

	// Individual source enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_en_r <= '0;
		end else if (wr_en) begin
			src_en_r <= hwdata[N_SRC-1:0];
		end
	end

	// Pending flags: a new edge beats a write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_r <= '0;
		end else begin
			flag_r <= (flag_r & ~(wr_flag ? hwdata[N_SRC-1:0] : '0)) |
				irq_src_set;
		end
	end

	// Wake ignores the global enable on purpose
	assign wake_c = |(src_en_r & flag_r);

	assign wdclr_cmd_c = wr_cmd && hwdata[swi_pkg::CMD_WDT_CLR];
	assign take_c = st_r == swi_pkg::ST_RUN && cyc_en && sleep_req_r;
	assign nop_c = take_c && wake_c;
	assign exec_done_c = st_r == swi_pkg::ST_EXEC && cyc_en;
	assign wdt_clr_c = wdclr_cmd_c || exec_done_c;

	// Power-down request waits for the next instruction boundary
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_req_r <= 1'b0;
		end else if (wr_cmd && hwdata[swi_pkg::CMD_SLEEP] &&
			st_r == swi_pkg::ST_RUN) begin
			sleep_req_r <= 1'b1;
		end else if (take_c) begin
			sleep_req_r <= 1'b0;
		end
	end

	// Sequencing of the power-down instruction
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			swi_pkg::ST_RUN: begin
				if (take_c && !wake_c) begin
					st_nxt = swi_pkg::ST_EXEC;
				end
			end
			swi_pkg::ST_EXEC: begin
				// Always completes its cycle before any wake
				if (cyc_en) begin
					st_nxt = wake_c ? swi_pkg::ST_RESUME :
						swi_pkg::ST_SLEEP;
				end
			end
			swi_pkg::ST_SLEEP: begin
				if (wake_c || wdt_tmo) begin
					st_nxt = swi_pkg::ST_RESUME;
				end
			end
			swi_pkg::ST_RESUME: begin
				if (cyc_en) begin
					st_nxt = swi_pkg::ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= swi_pkg::ST_RUN;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Oscillator driver off only while sleeping
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_run <= 1'b1;
			sleeping <= 1'b0;
		end else begin
			osc_run <= st_nxt != swi_pkg::ST_SLEEP;
			sleeping <= st_nxt == swi_pkg::ST_SLEEP;
		end
	end

	// Remember whether the wake came from a source, not the watchdog
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			woke_irq_r <= 1'b0;
		end else if (st_nxt == swi_pkg::ST_RESUME &&
			st_r != swi_pkg::ST_RESUME) begin
			woke_irq_r <= wake_c;
		end
	end

	// Prefetched instruction runs first, then optional vector
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_branch <= 1'b0;
		end else begin
			vector_branch <= st_r == swi_pkg::ST_RESUME && cyc_en &&
				woke_irq_r && glb_en_r;
		end
	end

	// Time-out flag; completion of power-down has the last word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_expired_n <= swi_pkg::EXPIRED_N_RST;
		end else if (exec_done_c) begin
			watchdog_expired_n <= 1'b1;
		end else if (wdt_tmo) begin
			watchdog_expired_n <= 1'b0;
		end else if (wdclr_cmd_c) begin
			watchdog_expired_n <= 1'b1;
		end
	end

	// Power-down flag; a no-op power-down leaves it alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_entered_n <= swi_pkg::SLEPT_N_RST;
		end else if (exec_done_c) begin
			sleep_entered_n <= 1'b0;
		end else if (wdt_tmo && st_r != swi_pkg::ST_SLEEP) begin
			sleep_entered_n <= 1'b1;
		end else if (wdclr_cmd_c) begin
			sleep_entered_n <= 1'b1;
		end
	end

	// Watchdog time-out while awake resets the core
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_reset <= 1'b0;
		end else begin
			wdt_reset <= wdt_tmo && st_r != swi_pkg::ST_SLEEP;
		end
	end

	// Sticky events, set beats write-one clear
	always_comb begin
		ev_set_c = '0;
		ev_set_c[swi_pkg::EV_NOP] = nop_c;
		ev_set_c[swi_pkg::EV_WAKE] = st_nxt == swi_pkg::ST_RESUME &&
			st_r != swi_pkg::ST_RESUME;
		ev_set_c[swi_pkg::EV_WDT] = wdt_tmo;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_r <= '0;
		end else begin
			ev_r <= (ev_r & ~(wr_evt ? hwdata[swi_pkg::EV_W-1:0] : '0)) |
				ev_set_c;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_mask_r <= '0;
		end else if (wr_mask) begin
			ev_mask_r <= hwdata[swi_pkg::EV_W-1:0];
		end
	end

	// Level interrupt, one cycle behind the masked event bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ev_r & ev_mask_r);
		end
	end

	swi_qdiv #(
		.PER(swi_pkg::OSC_PER_CYC)
	) u_qdiv (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(osc_run),
		.cyc_en_r(cyc_en)
	);

	swi_wdog #(
		.BASE(WDT_BASE_CYC),
		.PSW(PSW)
	) u_wdog (
		.hclk(hclk),
		.hresetn(hresetn),
		.en(wdt_en_r),
		.clr(wdt_clr_c),
		.ps_sel(ps_r),
		.tmo_r(wdt_tmo)
	);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_exec_done;
		st_r == swi_pkg::ST_EXEC && cyc_en;
	endsequence

	sequence s_take_quiet;
		take_c && wake_c && !wdt_tmo && !wdclr_cmd_c;
	endsequence

	AST_NOP_NO_SIDE: assert property (s_take_quiet |=>
		st_r == swi_pkg::ST_RUN &&
		sleep_entered_n == $past(sleep_entered_n) &&
		watchdog_expired_n == $past(watchdog_expired_n))
		else $error("no-op power-down changed state or flags");
	AST_NOP_SAMPLED: assert property (take_c |=>
		(st_r == swi_pkg::ST_EXEC) == !$past(wake_c))
		else $error("wake not sampled at power-down start");
	AST_GLB_EN_IGNORED: assert property (
		(st_r == swi_pkg::ST_SLEEP && wake_c && !glb_en_r) |=>
		st_r == swi_pkg::ST_RESUME)
		else $error("wake blocked by clear global enable");
	AST_ENABLE_NEEDED: assert property (
		(st_r == swi_pkg::ST_SLEEP && !wdt_tmo && !wake_c) |=>
		st_r == swi_pkg::ST_SLEEP)
		else $error("woke without an enabled pending source");
	AST_SLEEP_FLAGS: assert property (
		(s_exec_done ##0 !wake_c) |=> !osc_run && !sleep_entered_n &&
		watchdog_expired_n && st_r == swi_pkg::ST_SLEEP)
		else $error("power-down side effects missing");
	AST_LATE_WAKE: assert property (
		(s_exec_done ##0 wake_c) |=> st_r == swi_pkg::ST_RESUME &&
		osc_run && !sleep_entered_n && watchdog_expired_n)
		else $error("late wake did not resume with flags updated");
	AST_WDT_CLEARED: assert property (s_exec_done |=>
		u_wdog.base_r == '0 && u_wdog.post_r == '0)
		else $error("watchdog not cleared by power-down");
	AST_FINISH_FIRST: assert property (
		(st_r == swi_pkg::ST_EXEC && !cyc_en) |=>
		st_r == swi_pkg::ST_EXEC)
		else $error("power-down cut short by wake");
	AST_EXEC_BOUND: assert property (
		st_r == swi_pkg::ST_EXEC |-> ##[0:3] cyc_en)
		else $error("power-down cycle too long");
	AST_QUARTER_GAP: assert property (cyc_en |=> !cyc_en [*3])
		else $error("instruction cycle shorter than four clocks");
	AST_QUARTER_RATE: assert property (
		(cyc_en && osc_run) ##1 osc_run [*3] |=> cyc_en)
		else $error("instruction cycle longer than four clocks");
	AST_VECTOR: assert property (
		(st_r == swi_pkg::ST_RESUME && cyc_en && woke_irq_r) |=>
		vector_branch == $past(glb_en_r) && st_r == swi_pkg::ST_RUN)
		else $error("vector branch disagrees with global enable");

endmodule

// File: verilog/swi_pkg.sv
/*
 * Shared constants for the sleep/wake interrupt race controller:
 * register offsets, field positions, reset values, timing counts and
 * the controller state type.
 * Assumes a single 25 MHz core clock that also stands for the
 * oscillator time base.
 */
// Summary of operation
// - Enabled pending source wakes even without global enable
// - Wake already pending: power-down runs as no-op
// - Late wake: skip sleep, clear watchdog, set flags
// - Late wake: finish power-down fully before waking
// - One instruction cycle equals four oscillator periods
// - After wake, vector only when global enable set
// - Power-down clears watchdog and sleep_entered_n, sets watchdog_expired_n, stops oscillator
// - Only individually enabled sources or a watchdog time-out wake from sleep
package swi_pkg;

	// Clock and instruction timing
	localparam int CLK_HZ = 25_000_000;
	localparam int OSC_PER_CYC = 4;
	localparam int WDT_BASE_US = 18000;
	localparam int WDT_BASE_CYC = (CLK_HZ / 1_000_000) * WDT_BASE_US;

	// Sizes
	localparam int N_SRC = 8;
	localparam int PS_W = 3;

	// AHB-Lite encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SRC_EN = 8'h04;
	localparam logic [7:0] ADDR_SRC_FLAG = 8'h08;
	localparam logic [7:0] ADDR_CMD = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_EVT = 8'h14;
	localparam logic [7:0] ADDR_EVT_MASK = 8'h18;

	// Control register fields
	localparam int CTRL_GLB_EN = 0;
	localparam int CTRL_WDT_EN = 1;
	localparam int CTRL_PS_LSB = 2;

	// Command register fields (write only, self clearing)
	localparam int CMD_SLEEP = 0;
	localparam int CMD_WDT_CLR = 1;

	// Status register fields
	localparam int STAT_SLEEPING = 0;
	localparam int STAT_RESUMING = 1;
	localparam int STAT_SLEPT_N = 3;
	localparam int STAT_EXPIRED_N = 4;

	// Event register fields
	localparam int EV_W = 3;
	localparam int EV_NOP = 0;
	localparam int EV_WAKE = 1;
	localparam int EV_WDT = 2;

	// Reset values
	localparam logic GLB_EN_RST = 1'b0;
	localparam logic WDT_EN_RST = 1'b1;
	localparam logic [PS_W-1:0] PS_RST = 3'h0;
	localparam logic SLEPT_N_RST = 1'b1;
	localparam logic EXPIRED_N_RST = 1'b1;

	// Controller states, Gray along run, execute, sleep, resume
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_EXEC = 2'h1,
		ST_SLEEP = 2'h3,
		ST_RESUME = 2'h2
	} swi_state_t;

endpackage

// File: verilog/swi_qdiv.sv
/*
 * Instruction cycle divider: one enable pulse every PER clocks.
 * Assumes run is low while the oscillator driver is off.
 */
`timescale 1ns/1ps
module swi_qdiv #(
	parameter int PER = swi_pkg::OSC_PER_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	output logic cyc_en_r
);
	localparam int W = $clog2(PER);
	localparam logic [W-1:0] LAST = W'(PER - 1);

	logic [W-1:0] cnt_r;

	// Phase counter restarts from zero whenever the oscillator stops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
			cyc_en_r <= 1'b0;
		end else begin
			if (!run || cnt_r == LAST) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
			cyc_en_r <= run && cnt_r == LAST;
		end
	end

endmodule

// File: verilog/swi_wdog.sv
/*
 * Watchdog counter with a power-of-two postscaler.
 * Assumes it keeps counting while the core oscillator is stopped,
 * so it runs on hclk regardless of sleep.
 */
`timescale 1ns/1ps
module swi_wdog #(
	parameter int BASE = swi_pkg::WDT_BASE_CYC,
	parameter int PSW = swi_pkg::PS_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic en,
	input wire logic clr,
	input wire logic [PSW-1:0] ps_sel,
	output logic tmo_r
);
	localparam int BW = $clog2(BASE);
	localparam int PN = 1 << PSW;

	logic [BW-1:0] base_r;
	logic [PN-1:0] post_r;
	logic tick_c;
	logic [PN-1:0] lim_c;

	assign tick_c = base_r == BW'(BASE - 1);
	assign lim_c = ~({PN{1'b1}} << ps_sel);

	// Clear wins over counting so a clear never lets a timeout through
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			base_r <= '0;
			post_r <= '0;
			tmo_r <= 1'b0;
		end else begin
			tmo_r <= en && !clr && tick_c && post_r == lim_c;
			if (!en || clr) begin
				base_r <= '0;
				post_r <= '0;
			end else if (tick_c) begin
				base_r <= '0;
				post_r <= (post_r == lim_c) ? '0 : post_r + 1'b1;
			end else begin
				base_r <= base_r + 1'b1;
			end
		end
	end

endmodule
